/* File: dv/host_model.sv */
// host model that services pending flags while the interrupt pin is low
`timescale 1ns/1ps

module host_model
  import event_flag_pkg::*;
(
  input  wire logic         core_clk,            // core clock
  input  wire logic         rst_n,               // async reset, active low
  input  wire logic         service_en,          // host may service
  input  wire logic         interrupt_request_n, // interrupt pin, active low
  input  wire event_flags_s flags,               // flags read by the host
  output event_flags_s      flag_clear           // write-one clear pulses
);
  // on a low pin, write one back to every set flag for one cycle
  always @(negedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      flag_clear <= '0;
    end else if (service_en && !interrupt_request_n && flag_clear == '0) begin
      flag_clear <= flags;
    end else begin
      flag_clear <= '0;
    end
  end
endmodule : host_model

/* File: dv/tb.sv */
// directed testbench for the event flag unit
`timescale 1ns/1ps

module tb
  import event_flag_pkg::*;
;
  localparam int SC = 20;
  logic          core_clk, rst_n, ga, gb, pol, uv, srst, otp, svc;
  logic          out_a, out_b, pg_pin, buck_int, irq_n, dflt;
  logic [1:0]    en, regulator_on;
  event_inputs_s ci;
  event_masks_s  mk;
  event_flags_s  tb_clr, host_clr, e, flags;
  event_status_s status;
  int            mismatches, comparisons, cyc, k;

  pmic_event_flag_unit #(.SC_CYCLES(SC)) pmic_event_flag_unit_inst (
    .core_clk(core_clk), .rst_n(rst_n), .cond(ci), .mask(mk),
    .flag_clear(tb_clr | host_clr), .buck_enable_req(en),
    .general_output_a_req(ga), .general_output_b_req(gb),
    .power_good_pin_polarity(pol), .supply_undervoltage(uv),
    .soft_reset_req(srst), .otp_reset_mask(otp), .flags(flags),
    .status(status), .regulator_on(regulator_on), .general_output_a(out_a),
    .general_output_b(out_b), .power_good_pin(pg_pin), .buck_interrupt(buck_int),
    .interrupt_request_n(irq_n), .defaults_reset(dflt));

  host_model host_model_inst (
    .core_clk(core_clk), .rst_n(rst_n), .service_en(svc),
    .interrupt_request_n(irq_n), .flags(flags), .flag_clear(host_clr));

  // clock generation
  initial begin
    core_clk = 1'b0;
    forever #4 core_clk = ~core_clk;
  end

  task automatic close_out();
    if (mismatches == 0 && comparisons > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask : close_out

  // hang guard
  always @(posedge core_clk) begin
    cyc = cyc + 1;
    if (cyc == 2000) begin
      mismatches = mismatches + 1;
      close_out();
    end
  end

  task automatic step(input int n);
    repeat (n) @(negedge core_clk);
  endtask : step

  task automatic clr(input event_flags_s f);
    tb_clr = f;
    step(1);
    tb_clr = '0;
  endtask : clr

  task automatic cmp_f(input event_flags_s exp);
    comparisons++;
    if (flags !== exp) begin
      mismatches++;
      $display("ERROR %0t flags %h expected %h", $time, flags, exp);
    end
  endtask : cmp_f

  task automatic cmp_b(input logic [3:0] got, input logic [3:0] exp);
    comparisons++;
    if (got !== exp) begin
      mismatches++;
      $display("ERROR %0t value %h expected %h", $time, got, exp);
    end
  endtask : cmp_b

  // directed sequence
  initial begin
    {ga, gb, pol, uv, srst, otp, svc, en} = '0;
    {ci, mk, tb_clr, e} = '0;
    {mismatches, comparisons, cyc} = '0;
    rst_n = 1'b0;
    step(6);
    rst_n = 1'b1;
    step(1);
    e.reset_event = 1'b1;
    cmp_f(e);
    cmp_b({irq_n, dflt}, 4'h0);
    clr(e);
    cmp_b(irq_n, 4'h1);
    // current limit, live status, clear refused while active
    en = 2'b11;
    ci.current_limit = 2'b01;
    step(1);
    e = '0;
    e.current_limit = 2'b01;
    cmp_f(e);
    cmp_b({status.current_limit, buck_int, irq_n}, 4'h6);
    cmp_b(regulator_on, 4'h3);
    clr(e);
    cmp_f(e);
    ci.current_limit = 2'b00;
    clr(e);
    cmp_f('0);
    cmp_b({buck_int, irq_n}, 4'h1);
    mk.current_limit = 2'b10;
    ci.current_limit = 2'b10;
    step(1);
    cmp_f('0);
    cmp_b(status.current_limit, 4'h2);
    {ci, mk} = '0;
    // buck 0 low from enable, buck 1 falls low while running
    for (k = 0; k < 2; k++) begin
      en = 2'b01 << k;
      ci.output_low = (k == 0) ? 2'b01 : 2'b00;
      step(5);
      ci.output_low = en;
      cmp_b(regulator_on, en);
      step(SC - 8);
      cmp_b(regulator_on, en);
      step(12);
      e = '0;
      e.short_circuit = en;
      cmp_f(e);
      cmp_b({regulator_on, buck_int}, 4'h1);
      en = 2'b00;
      ci.output_low = 2'b00;
      step(1);
      clr(e);
      cmp_f('0);
    end
    // warning, thermal shutdown, supply overvoltage
    for (k = 0; k < 3; k++) begin
      en = 2'b11;
      {ga, gb} = 2'b11;
      step(2);
      {ci.thermal_warning, ci.thermal_shutdown, ci.supply_overvoltage} = 3'b100 >> k;
      e = '0;
      {e.thermal_warning, e.thermal_shutdown, e.supply_overvoltage} = 3'b100 >> k;
      step(1);
      cmp_f(e);
      cmp_b({status.thermal_warning, status.thermal_shutdown,
             status.supply_overvoltage}, 3'b100 >> k);
      cmp_b({regulator_on, out_a, out_b}, (k == 0) ? 4'hf : 4'h0);
      clr(e);
      cmp_f(e);
      ci = '0;
      step(1);
      clr(e);
      cmp_f('0);
    end
    {en, ga, gb} = '0;
    // output valid rise and fall, each with its own mask
    ci.output_valid = 2'b01;
    step(1);
    e = '0;
    e.output_valid = 2'b01;
    cmp_f(e);
    cmp_b({status.output_valid, buck_int}, 4'h3);
    clr(e);
    mk.output_valid_fall = 2'b01;
    ci.output_valid = 2'b00;
    step(2);
    cmp_f('0);
    mk.output_valid_rise = 2'b01;
    ci.output_valid = 2'b01;
    step(2);
    cmp_f('0);
    mk = '0;
    ci.output_valid = 2'b00;
    step(1);
    cmp_f(e);
    clr(e);
    // power-good pin, polarity, flag on active to inactive
    ci.power_good_valid = 1'b1;
    step(2);
    cmp_b({pg_pin, status.power_good_pin}, 4'h3);
    cmp_f('0);
    pol = 1'b1;
    step(2);
    cmp_b({pg_pin, status.power_good_pin}, 4'h1);
    ci.power_good_valid = 1'b0;
    step(1);
    e = '0;
    e.power_good_pin = 1'b1;
    cmp_f(e);
    cmp_b({pg_pin, status.power_good_pin}, 4'h2);
    clr(e);
    cmp_f('0);
    pol = 1'b0;
    // sync clock appears, disappears, absent with detector enabled
    e = '0;
    e.sync_clock = 1'b1;
    for (k = 0; k < 3; k++) begin
      {ci.clock_detector_enable, ci.sync_clock_present} = (k == 2) ? 2'b10 : 2'b01 >> k;
      step(1);
      cmp_f(e);
      cmp_b(status.sync_clock, (k == 0) ? 4'h1 : 4'h0);
      clr(e);
      cmp_f((k == 2) ? e : '0);
    end
    ci = '0;
    step(1);
    clr(e);
    cmp_f('0);
    // measurement ready, masked then serviced by the host
    mk.measurement_ready = 1'b1;
    ci.measurement_done = 1'b1;
    step(1);
    ci.measurement_done = 1'b0;
    cmp_f('0);
    mk = '0;
    svc = 1'b1;
    ci.measurement_done = 1'b1;
    step(1);
    ci.measurement_done = 1'b0;
    e = '0;
    e.measurement_ready = 1'b1;
    cmp_f(e);
    cmp_b(irq_n, 4'h0);
    for (k = 0; k < 10 && irq_n !== 1'b1; k++) step(1);
    cmp_b(irq_n, 4'h1);
    cmp_f('0);
    svc = 1'b0;
    // software reset, then with the one-time mask set
    en = 2'b11;
    ga = 1'b1;
    step(2);
    srst = 1'b1;
    step(1);
    {srst, en, ga} = '0;
    cmp_b({regulator_on, out_a, dflt}, 4'h1);
    step(2);
    e = '0;
    e.reset_event = 1'b1;
    cmp_f(e);
    cmp_b(dflt, 4'h0);
    clr(e);
    cmp_f('0);
    otp = 1'b1;
    srst = 1'b1;
    step(1);
    srst = 1'b0;
    step(3);
    cmp_f('0);
    otp = 1'b0;
    // supply undervoltage and recovery
    ci.measurement_done = 1'b1;
    step(1);
    uv = 1'b1;
    ci.thermal_warning = 1'b1;
    step(3);
    cmp_f('0);
    cmp_b({irq_n, dflt}, 4'h3);
    uv = 1'b0;
    ci = '0;
    step(3);
    cmp_f(e);
    close_out();
  end
endmodule : tb

/* File: hdl/event_flag_pkg.sv */
// shared constants and carrier types for the event flag unit
package event_flag_pkg;

  localparam int NUM_BUCKS     = 2;           // buck regulators served
  localparam int CLK_FREQ_MHZ  = 125;         // core_clk rate
  localparam int SHORT_TIME_US = 1000;        // short-circuit window and debounce, us
  localparam int SHORT_CYCLES  = SHORT_TIME_US * CLK_FREQ_MHZ;

  // reset sequencer states
  typedef enum logic [1:0] {
    st_run  = 2'h0,                           // normal operation
    st_down = 2'h1,                           // supply undervoltage, held shut down
    st_load = 2'h2                            // defaults and one-time bits loading
  } seq_state_e;

  // sticky flags, also the layout of write-one clears
  typedef struct packed {
    logic [1:0] current_limit;
    logic [1:0] short_circuit;
    logic [1:0] output_valid;
    logic       thermal_warning;
    logic       thermal_shutdown;
    logic       supply_overvoltage;
    logic       power_good_pin;
    logic       sync_clock;
    logic       measurement_ready;
    logic       reset_event;
  } event_flags_s;

  // software masks, one gates the setting of its flag
  typedef struct packed {
    logic [1:0] current_limit;
    logic [1:0] output_valid_rise;
    logic [1:0] output_valid_fall;
    logic       thermal_warning;
    logic       power_good_pin;
    logic       sync_clock;
    logic       measurement_ready;
  } event_masks_s;

  // live conditions from the analog side
  typedef struct packed {
    logic [1:0] current_limit;
    logic [1:0] output_low;
    logic [1:0] output_valid;
    logic       thermal_warning;
    logic       thermal_shutdown;
    logic       supply_overvoltage;
    logic       power_good_valid;
    logic       sync_clock_present;
    logic       clock_detector_enable;
    logic       measurement_done;
  } event_inputs_s;

  // live status bits
  typedef struct packed {
    logic [1:0] current_limit;
    logic [1:0] output_valid;
    logic       thermal_warning;
    logic       thermal_shutdown;
    logic       supply_overvoltage;
    logic       power_good_pin;
    logic       sync_clock;
  } event_status_s;

  localparam event_flags_s  FLAGS_RESET  = '0;
  localparam event_status_s STATUS_RESET = '0;

endpackage : event_flag_pkg

/* File: hdl/pmic_event_flag_unit.sv */
// event flags, regulator protection and reset sequencing of the power device
//
// Behaviour
// - current limit sets maskable flag and live status; regulator keeps running
// - write one clears current-limit flag unless limit still active
// - output below threshold 1 ms after enable disables buck, sets short flag
// - output low for 1 ms debounce while running does the same
// - write one clears the short-circuit flag
// - thermal warning sets maskable flag and status; clear blocked while hot
// - thermal shutdown kills regulators and outputs, sets sticky unmaskable flag
// - supply overvoltage kills regulators and outputs, sets sticky unmaskable flag
// - output becoming valid sets its flag unless rise mask; status shows validity
// - output becoming invalid sets same flag unless fall mask
// - power-good going inactive sets maskable flag with status; write one clears
// - power-good status is 1 when valid; polarity inverts only the pin
// - sync clock appearing or vanishing sets maskable flag with status
// - sync flag also raised while clock absent and detector enabled
// - measurement done sets maskable flag without status; write one clears
// - supply undervoltage shuts down and resets everything except the power-good pin, no flag
// - supply recovery loads defaults and one-time bits, sets reset flag
// - software reset shuts down, restarts, sets reset flag; write one clears
// - interrupt pin low while any flag pending
// - reset flag mask comes from one-time storage at reset sequence only
`timescale 1ns/1ps

module pmic_event_flag_unit
  import event_flag_pkg::*;
#(
  parameter int SC_CYCLES = SHORT_CYCLES      // short-circuit window in clocks
) (
  input  wire logic                 core_clk,                // core clock
  input  wire logic                 rst_n,                   // async reset, power-on
  input  wire event_inputs_s        cond,                    // live analog conditions
  input  wire event_masks_s         mask,                    // software masks
  input  wire event_flags_s         flag_clear,              // write-one clear pulses
  input  wire logic [1:0]           buck_enable_req,         // regulator enable requests
  input  wire logic                 general_output_a_req,    // requested level of output a
  input  wire logic                 general_output_b_req,    // requested level of output b
  input  wire logic                 power_good_pin_polarity, // 1 inverts the pin
  input  wire logic                 supply_undervoltage,     // analog supply below lockout
  input  wire logic                 soft_reset_req,          // software reset pulse
  input  wire logic                 otp_reset_mask,          // one-time reset flag mask
  output event_flags_s              flags,                   // sticky flags
  output event_status_s             status,                  // live status bits
  output logic [1:0]                regulator_on,            // buck enables
  output logic                      general_output_a,        // general output a
  output logic                      general_output_b,        // general output b
  output logic                      power_good_pin,          // pin level after polarity
  output logic                      buck_interrupt,          // buck summary bit
  output logic                      interrupt_request_n,     // interrupt pin, active low
  output logic                      defaults_reset           // registers held at defaults
);

  localparam int CW = $clog2(SC_CYCLES + 1);

  seq_state_e       state;
  seq_state_e       next_state;
  event_flags_s     next_flags;
  logic             reset_mask;
  logic [1:0]       valid_prev;
  logic             pg_prev;
  logic             sync_prev;
  logic [1:0]       sc_latched;
  logic [1:0]       sc_trip;
  logic [CW-1:0]    sc_count [NUM_BUCKS];
  logic             live;
  logic             fault_off;

  assign live      = (state == st_run) && !soft_reset_req && !supply_undervoltage;
  assign fault_off = cond.thermal_shutdown || cond.supply_overvoltage;

  // reset sequencer: undervoltage hold, then defaults and one-time load
  always_comb begin
    next_state = state;
    case (state)
      st_run:  begin
        if (supply_undervoltage) next_state = st_down;
        else if (soft_reset_req) next_state = st_load;
      end
      st_down: begin
        if (!supply_undervoltage) next_state = st_load;
      end
      st_load: begin
        next_state = supply_undervoltage ? st_down : st_run;
      end
      default: next_state = st_down;
    endcase
  end

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) state <= st_load;
    else        state <= next_state;
  end

  // reset flag mask only taken from one-time storage while loading
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n)                 reset_mask <= 1'h0;
    else if (state == st_load)  reset_mask <= otp_reset_mask;
  end

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) defaults_reset <= 1'h1;
    else        defaults_reset <= (next_state != st_run);
  end

  // short-circuit window per buck: low output while enabled for the window
  for (genvar i = 0; i < NUM_BUCKS; i++) begin : g_buck
    assign sc_trip[i] = regulator_on[i] && cond.output_low[i]
                        && (sc_count[i] == CW'(SC_CYCLES - 1));

    always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n)                                       sc_count[i] <= '0;
      else if (!regulator_on[i] || !cond.output_low[i]) sc_count[i] <= '0;
      else if (!sc_trip[i])                             sc_count[i] <= sc_count[i] + 1'b1;
    end

    // a tripped buck stays off until its enable request is withdrawn or the unit leaves normal operation
    always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n)                    sc_latched[i] <= 1'h0;
      else if (!live)                sc_latched[i] <= 1'h0;
      else if (sc_trip[i])           sc_latched[i] <= 1'h1;
      else if (!buck_enable_req[i])  sc_latched[i] <= 1'h0;
    end

    always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) regulator_on[i] <= 1'h0;
      else        regulator_on[i] <= live && buck_enable_req[i] && !fault_off
                                     && !sc_latched[i] && !sc_trip[i];
    end

    chk_sc_trip_off: assert property (
      @(posedge core_clk) disable iff (!rst_n)
      live && sc_trip[i] |=> !regulator_on[i] && flags.short_circuit[i])
      else $error("short circuit did not disable buck and set flag");

    chk_cl_hold: assert property (
      @(posedge core_clk) disable iff (!rst_n)
      live && flags.current_limit[i] && cond.current_limit[i] |=> flags.current_limit[i])
      else $error("current limit flag cleared while limit active");

    chk_valid_rise: assert property (
      @(posedge core_clk) disable iff (!rst_n)
      live && cond.output_valid[i] && !valid_prev[i] && !mask.output_valid_rise[i]
      |=> flags.output_valid[i] && status.output_valid[i])
      else $error("output valid rise did not set flag");

    chk_valid_fall: assert property (
      @(posedge core_clk) disable iff (!rst_n)
      live && !cond.output_valid[i] && valid_prev[i] && !mask.output_valid_fall[i]
      |=> flags.output_valid[i])
      else $error("output valid fall did not set flag");
  end

  // edge history for change-type events
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      valid_prev <= 2'h0;
      pg_prev    <= 1'h0;
      sync_prev  <= 1'h0;
    end else begin
      valid_prev <= cond.output_valid;
      pg_prev    <= cond.power_good_valid;
      sync_prev  <= cond.sync_clock_present;
    end
  end

  // sticky flags: the set term always wins over a write-one clear
  always_comb begin
    next_flags = FLAGS_RESET;
    if (state == st_load && !supply_undervoltage) begin
      next_flags.reset_event = !otp_reset_mask;
    end else if (live) begin
      next_flags = flags & ~flag_clear;
      next_flags.current_limit = next_flags.current_limit
        | (flags.current_limit & cond.current_limit)
        | (cond.current_limit & ~mask.current_limit);
      next_flags.short_circuit = next_flags.short_circuit | sc_trip;
      next_flags.output_valid = next_flags.output_valid
        | (cond.output_valid & ~valid_prev & ~mask.output_valid_rise)
        | (~cond.output_valid & valid_prev & ~mask.output_valid_fall);
      next_flags.thermal_warning = next_flags.thermal_warning
        | (flags.thermal_warning && cond.thermal_warning)
        | (cond.thermal_warning && !mask.thermal_warning);
      next_flags.thermal_shutdown = next_flags.thermal_shutdown
        | cond.thermal_shutdown;
      next_flags.supply_overvoltage = next_flags.supply_overvoltage
        | cond.supply_overvoltage;
      next_flags.power_good_pin = next_flags.power_good_pin
        | (pg_prev && !cond.power_good_valid && !mask.power_good_pin);
      next_flags.sync_clock = next_flags.sync_clock
        | (!mask.sync_clock
           && ((cond.sync_clock_present != sync_prev)
               || (cond.clock_detector_enable && !cond.sync_clock_present)));
      next_flags.measurement_ready = next_flags.measurement_ready
        | (cond.measurement_done && !mask.measurement_ready);
    end
  end

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) flags <= FLAGS_RESET;
    else        flags <= next_flags;
  end

  // interrupt pin and buck summary follow the flags that will stand
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      interrupt_request_n <= 1'h1;
      buck_interrupt      <= 1'h0;
    end else begin
      interrupt_request_n <= !(|next_flags);
      buck_interrupt      <= |{next_flags.current_limit, next_flags.short_circuit,
                               next_flags.output_valid};
    end
  end

  // live status bits, cleared to defaults outside normal operation
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      status <= STATUS_RESET;
    end else if (next_state != st_run) begin
      status <= STATUS_RESET;
    end else begin
      status.current_limit      <= cond.current_limit;
      status.output_valid       <= cond.output_valid;
      status.thermal_warning    <= cond.thermal_warning;
      status.thermal_shutdown   <= cond.thermal_shutdown;
      status.supply_overvoltage <= cond.supply_overvoltage;
      status.power_good_pin     <= cond.power_good_valid;
      status.sync_clock         <= cond.sync_clock_present;
    end
  end

  // pin polarity touches the pin only
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) power_good_pin <= 1'h0;
    else        power_good_pin <= cond.power_good_valid ^ power_good_pin_polarity;
  end

  // general outputs forced low by faults and by reset
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      general_output_a <= 1'h0;
      general_output_b <= 1'h0;
    end else begin
      general_output_a <= live && !fault_off && general_output_a_req;
      general_output_b <= live && !fault_off && general_output_b_req;
    end
  end

  sequence s_restart;
    (state == st_load) && !supply_undervoltage ##1 (state == st_run);
  endsequence

  chk_reset_flag: assert property (
    @(posedge core_clk) disable iff (!rst_n)
    s_restart |-> flags.reset_event == !reset_mask)
    else $error("reset flag does not follow one-time mask");

  chk_soft_reset: assert property (
    @(posedge core_clk) disable iff (!rst_n)
    (state == st_run) && soft_reset_req && !supply_undervoltage
    |=> regulator_on == 2'h0 && defaults_reset ##1 state == st_run)
    else $error("software reset did not restart");

  chk_uvlo_quiet: assert property (
    @(posedge core_clk) disable iff (!rst_n)
    supply_undervoltage [*2] |-> flags == FLAGS_RESET && regulator_on == 2'h0)
    else $error("undervoltage left flags or regulators set");

  chk_fault_off: assert property (
    @(posedge core_clk) disable iff (!rst_n)
    fault_off |=> regulator_on == 2'h0 && !general_output_a && !general_output_b)
    else $error("fault did not shut regulators and outputs");

  chk_ovp_hold: assert property (
    @(posedge core_clk) disable iff (!rst_n)
    live && cond.supply_overvoltage |=> flags.supply_overvoltage)
    else $error("overvoltage flag not held");

  chk_tw_hold: assert property (
    @(posedge core_clk) disable iff (!rst_n)
    live && cond.thermal_warning && !mask.thermal_warning |=> flags.thermal_warning)
    else $error("thermal warning flag not held");

  chk_irq_pin: assert property (
    @(posedge core_clk) disable iff (!rst_n)
    $rose(|flags) |-> !interrupt_request_n throughout (|flags) [*1])
    else $error("interrupt pin not low with pending flags");

  chk_pg_polarity: assert property (
    @(posedge core_clk) disable iff (!rst_n)
    live ##1 (state == st_run) |-> power_good_pin ==
      (status.power_good_pin ^ $past(power_good_pin_polarity)))
    else $error("pin polarity leaked into status");

  // an unmasked presence change of the sync clock raises its flag
  chk_sync_change: assert property (
    @(posedge core_clk) disable iff (!rst_n)
    live && !mask.sync_clock && (cond.sync_clock_present != sync_prev) |=> flags.sync_clock)
    else $error("sync clock change did not set flag");

  // absent clock with detector on keeps raising the flag
  chk_sync_absent: assert property (
    @(posedge core_clk) disable iff (!rst_n)
    live && !mask.sync_clock && cond.clock_detector_enable && !cond.sync_clock_present
    |=> flags.sync_clock)
    else $error("absent sync clock did not set flag");

  // finished measurement raises its flag unless masked
  chk_meas_ready: assert property (
    @(posedge core_clk) disable iff (!rst_n)
    live && cond.measurement_done && !mask.measurement_ready |=> flags.measurement_ready)
    else $error("measurement done did not set flag");

  // power-good going inactive raises the pin flag
  chk_pg_fall: assert property (
    @(posedge core_clk) disable iff (!rst_n)
    live && pg_prev && !cond.power_good_valid && !mask.power_good_pin
    |=> flags.power_good_pin)
    else $error("power good fall did not set flag");

  // summary bit always matches the per-buck flags
  chk_buck_summary: assert property (
    @(posedge core_clk) disable iff (!rst_n)
    buck_interrupt == (|{flags.current_limit, flags.short_circuit, flags.output_valid}))
    else $error("buck summary differs from buck flags");

  // pin level always matches the pending flags
  chk_irq_level: assert property (
    @(posedge core_clk) disable iff (!rst_n)
    interrupt_request_n == !(|flags))
    else $error("interrupt pin differs from pending flags");

  // write one removes a short flag when no new trip comes
  chk_sc_clear: assert property (
    @(posedge core_clk) disable iff (!rst_n)
    live && (flag_clear.short_circuit != 2'h0) && (sc_trip == 2'h0)
    |=> (flags.short_circuit & $past(flag_clear.short_circuit)) == 2'h0)
    else $error("short flag not cleared by write one");

  // undervoltage holds defaults and forces outputs low
  chk_down_outputs: assert property (
    @(posedge core_clk) disable iff (!rst_n)
    supply_undervoltage |=> defaults_reset && !general_output_a && !general_output_b)
    else $error("undervoltage left outputs driven");

endmodule : pmic_event_flag_unit
